// file: rtl/tec_pkg.sv
/*
  Constants for the sixteen-bit timer and event counter channel:
  register byte offsets, field positions, mode codes, prescaler masks.
  Assumes a 12-bit APB byte address and 32-bit data.
*/
package tec_pkg;

  localparam int unsigned TEC_ADDR_W = 12;
  localparam int unsigned TEC_CNT_W  = 16;

  // Register byte offsets, one aligned word each
  localparam logic [11:0] TEC_OFS_ENABLE   = 12'h000;
  localparam logic [11:0] TEC_OFS_RUN      = 12'h004;
  localparam logic [11:0] TEC_OFS_CONTROL  = 12'h008;
  localparam logic [11:0] TEC_OFS_MODE     = 12'h00C;
  localparam logic [11:0] TEC_OFS_FFCTRL   = 12'h010;
  localparam logic [11:0] TEC_OFS_STATUS   = 12'h014;
  localparam logic [11:0] TEC_OFS_MASK     = 12'h018;
  localparam logic [11:0] TEC_OFS_SNAPSHOT = 12'h01C;
  localparam logic [11:0] TEC_OFS_COMPARE0 = 12'h020;
  localparam logic [11:0] TEC_OFS_COMPARE1 = 12'h024;
  localparam logic [11:0] TEC_OFS_CAPTURE0 = 12'h028;
  localparam logic [11:0] TEC_OFS_CAPTURE1 = 12'h02C;

  // channel_enable fields
  localparam int unsigned TEC_EN_BIT   = 7;
  localparam int unsigned TEC_HALT_BIT = 6;
  // run_control fields
  localparam int unsigned TEC_RUN_BIT  = 0;
  localparam int unsigned TEC_PRUN_BIT = 2;
  // timer_control fields
  localparam int unsigned TEC_DBUF_BIT  = 7;
  localparam int unsigned TEC_TRGF_BIT  = 1;
  localparam int unsigned TEC_START_BIT = 0;
  // timer_mode fields
  localparam int unsigned TEC_CLKSEL_LSB = 0;
  localparam int unsigned TEC_CLREN_BIT  = 3;
  localparam int unsigned TEC_CAPM_LSB   = 4;
  localparam int unsigned TEC_SNAP_BIT   = 6;
  // flipflop_control fields
  localparam int unsigned TEC_FFACT_LSB = 0;
  localparam int unsigned TEC_INV0_BIT  = 2;
  localparam int unsigned TEC_INV1_BIT  = 3;
  // event_status and interrupt_mask layout
  localparam int unsigned TEC_ST_MATCH0 = 0;
  localparam int unsigned TEC_ST_MATCH1 = 1;
  localparam int unsigned TEC_ST_OVF    = 2;
  localparam int unsigned TEC_ST_W      = 3;

  // Clock source codes
  localparam logic [1:0] TEC_CLK_EXT   = 2'h0;
  localparam logic [1:0] TEC_CLK_DIV2  = 2'h1;
  localparam logic [1:0] TEC_CLK_DIV8  = 2'h2;
  localparam logic [1:0] TEC_CLK_DIV32 = 2'h3;
  // Prescaler phase masks per divide ratio
  localparam logic [4:0] TEC_MASK_DIV2  = 5'h01;
  localparam logic [4:0] TEC_MASK_DIV8  = 5'h07;
  localparam logic [4:0] TEC_MASK_DIV32 = 5'h1F;

  // Capture modes
  localparam logic [1:0] TEC_CAP_OFF    = 2'h0;
  localparam logic [1:0] TEC_CAP_WIDTH  = 2'h1;
  localparam logic [1:0] TEC_CAP_PERIOD = 2'h2;
  localparam logic [1:0] TEC_CAP_GATE   = 2'h3;

  // Flip-flop actions on write
  localparam logic [1:0] TEC_FF_INVERT = 2'h0;
  localparam logic [1:0] TEC_FF_SET    = 2'h1;
  localparam logic [1:0] TEC_FF_CLEAR  = 2'h2;
  localparam logic [1:0] TEC_FF_KEEP   = 2'h3;

  localparam logic [15:0] TEC_CNT_MAX = 16'hFFFF;

endpackage

// file: rtl/tec_timer_channel.sv
/*
  One sixteen-bit timer and event counter channel with an APB slave.
  Assumes I_TIMER_IN is an asynchronous pin, I_DBG_HALT comes from logic on
  I_CLK_SYS, and the APB master follows the usual setup/access protocol.
*/
// Our own choice: the APB slave port.
`timescale 1ns/1ps

module tec_timer_channel (
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_RST,
  input  wire logic        I_PSEL,
  input  wire logic        I_PENABLE,
  input  wire logic        I_PWRITE,
  input  wire logic [11:0] I_PADDR,
  input  wire logic [31:0] I_PWDATA,
  input  wire logic        I_DBG_HALT,
  input  wire logic        I_TIMER_IN,
  output logic      [31:0] O_PRDATA,
  output logic             O_PREADY,
  output logic             O_PSLVERR,
  output logic             O_IRQ,
  output logic             O_TIMER_FF
);

  typedef struct packed {
    logic        sync1;
    logic        sync2;
    logic        sync3;
    logic        en;
    logic        halt;
    logic        run;
    logic        prun;
    logic        dbuf;
    logic        trg_fall;
    logic        start_ext;
    logic [1:0]  clk_sel;
    logic        clr_en;
    logic [1:0]  cap_mode;
    logic        inv0;
    logic        inv1;
    logic [2:0]  status;
    logic [2:0]  imask;
    logic [15:0] snap;
    logic [15:0] rg0_buf;
    logic [15:0] rg1_buf;
    logic [15:0] rg0;
    logic [15:0] rg1;
    logic [15:0] cp0;
    logic [15:0] cp1;
    logic [15:0] cnt;
    logic [4:0]  presc;
    logic        started;
    logic        tff;
    logic        irq;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } tec_state_s;

  localparam tec_state_s TEC_RESET = '0;

  tec_state_s s;
  tec_state_s next_s;

  logic        ce;
  logic        done;
  logic        mapped;
  logic        sel_en;
  logic        wr_ok;
  logic        rise;
  logic        fall;
  logic        trig;
  logic        ptick;
  logic        tick;
  logic        match0;
  logic        match1;
  logic        wrap;
  logic        ovf;
  logic [4:0]  pmask;
  logic [31:0] rdata;
  logic [2:0]  st_set;
  logic [2:0]  st_clr;

  always_comb
  begin
    next_s = s;
    // Input pin synchroniser and edge history
    next_s.sync1 = I_TIMER_IN;
    next_s.sync2 = s.sync1;
    next_s.sync3 = s.sync2;
    rise = s.sync2 & ~s.sync3;
    fall = ~s.sync2 & s.sync3;
    trig = s.trg_fall ? fall : rise;

    ce = s.en && !(s.halt && I_DBG_HALT);

    done   = I_PSEL && I_PENABLE && s.pready;
    mapped = (I_PADDR[1:0] == 2'h0) && (I_PADDR <= tec_pkg::TEC_OFS_CAPTURE1);
    sel_en = (I_PADDR == tec_pkg::TEC_OFS_ENABLE);
    wr_ok  = done && I_PWRITE && mapped && (s.en || sel_en);

    // Prescaler, cleared while stopped
    next_s.presc = !s.prun ? 5'h00 : (ce ? s.presc + 5'h01 : s.presc);
    unique case (s.clk_sel)
      tec_pkg::TEC_CLK_DIV2:  pmask = tec_pkg::TEC_MASK_DIV2;
      tec_pkg::TEC_CLK_DIV8:  pmask = tec_pkg::TEC_MASK_DIV8;
      tec_pkg::TEC_CLK_DIV32: pmask = tec_pkg::TEC_MASK_DIV32;
      tec_pkg::TEC_CLK_EXT:   pmask = 5'h00;
    endcase
    ptick = (s.clk_sel == tec_pkg::TEC_CLK_EXT) ? rise
          : (s.prun && ((s.presc & pmask) == pmask));

    next_s.started = s.run && (s.started || (ce && s.start_ext && trig));
    tick   = ce && s.run && (s.started || !s.start_ext) && ptick;
    match0 = tick && (s.cnt == s.rg0);
    match1 = tick && (s.cnt == s.rg1);
    wrap   = match1 && s.clr_en;
    ovf    = tick && (s.cnt == tec_pkg::TEC_CNT_MAX) && !wrap;

    if (!s.run)
    begin
      next_s.cnt = 16'h0000;
    end
    else if (ce && s.start_ext && trig && !s.started)
    begin
      next_s.cnt = 16'h0000;
    end
    else if (tick)
    begin
      next_s.cnt = wrap ? 16'h0000 : s.cnt + 16'h0001;
    end

    if (wrap && s.dbuf)
    begin
      next_s.rg0 = s.rg0_buf;
      next_s.rg1 = s.rg1_buf;
    end

    if (ce)
    begin
      unique case (s.cap_mode)
        tec_pkg::TEC_CAP_WIDTH:
        begin
          if (rise)
          begin
            next_s.cp0 = s.cnt;
          end
          if (fall)
          begin
            next_s.cp1 = s.cnt;
          end
        end
        tec_pkg::TEC_CAP_PERIOD:
        begin
          if (rise)
          begin
            next_s.cp0 = s.cp1;
            next_s.cp1 = s.cnt;
          end
        end
        tec_pkg::TEC_CAP_GATE:
        begin
          if (rise)
          begin
            next_s.cp0 = s.cnt;
          end
          if (match1)
          begin
            next_s.cp1 = s.cnt;
          end
        end
        tec_pkg::TEC_CAP_OFF:    next_s.cp0 = s.cp0;
      endcase
    end

    next_s.tff = s.tff ^ (match0 && s.inv0) ^ (match1 && s.inv1);

    st_set = '0;
    st_set[tec_pkg::TEC_ST_MATCH0] = match0;
    st_set[tec_pkg::TEC_ST_MATCH1] = match1;
    st_set[tec_pkg::TEC_ST_OVF]    = ovf;
    st_clr = '0;

    // Register writes, taken at the completing edge
    if (wr_ok)
    begin
      unique case (I_PADDR)
        tec_pkg::TEC_OFS_ENABLE:
        begin
          next_s.en   = I_PWDATA[tec_pkg::TEC_EN_BIT];
          next_s.halt = I_PWDATA[tec_pkg::TEC_HALT_BIT];
        end
        tec_pkg::TEC_OFS_RUN:
        begin
          next_s.run  = I_PWDATA[tec_pkg::TEC_RUN_BIT];
          next_s.prun = I_PWDATA[tec_pkg::TEC_PRUN_BIT];
        end
        tec_pkg::TEC_OFS_CONTROL:
        begin
          next_s.dbuf      = I_PWDATA[tec_pkg::TEC_DBUF_BIT];
          next_s.trg_fall  = I_PWDATA[tec_pkg::TEC_TRGF_BIT];
          next_s.start_ext = I_PWDATA[tec_pkg::TEC_START_BIT];
        end
        tec_pkg::TEC_OFS_MODE:
        begin
          next_s.clk_sel  = I_PWDATA[tec_pkg::TEC_CLKSEL_LSB +: 2];
          next_s.clr_en   = I_PWDATA[tec_pkg::TEC_CLREN_BIT];
          next_s.cap_mode = I_PWDATA[tec_pkg::TEC_CAPM_LSB +: 2];
          if (!I_PWDATA[tec_pkg::TEC_SNAP_BIT])
          begin
            next_s.snap = s.cnt;
          end
        end
        tec_pkg::TEC_OFS_FFCTRL:
        begin
          next_s.inv0 = I_PWDATA[tec_pkg::TEC_INV0_BIT];
          next_s.inv1 = I_PWDATA[tec_pkg::TEC_INV1_BIT];
          unique case (I_PWDATA[tec_pkg::TEC_FFACT_LSB +: 2])
            tec_pkg::TEC_FF_INVERT: next_s.tff = ~s.tff;
            tec_pkg::TEC_FF_SET:    next_s.tff = 1'h1;
            tec_pkg::TEC_FF_CLEAR:  next_s.tff = 1'h0;
            tec_pkg::TEC_FF_KEEP:   next_s.tff = next_s.tff;
          endcase
        end
        tec_pkg::TEC_OFS_STATUS:
        begin
          st_clr = I_PWDATA[tec_pkg::TEC_ST_W-1:0];
        end
        tec_pkg::TEC_OFS_MASK:
        begin
          next_s.imask = I_PWDATA[tec_pkg::TEC_ST_W-1:0];
        end
        tec_pkg::TEC_OFS_COMPARE0:
        begin
          next_s.rg0_buf = I_PWDATA[15:0];
          if (!s.dbuf)
          begin
            next_s.rg0 = I_PWDATA[15:0];
          end
        end
        tec_pkg::TEC_OFS_COMPARE1:
        begin
          next_s.rg1_buf = I_PWDATA[15:0];
          if (!s.dbuf)
          begin
            next_s.rg1 = I_PWDATA[15:0];
          end
        end
        default: next_s.snap = next_s.snap;
      endcase
    end

    // Sticky status, a new event beats the clear
    next_s.status = (s.status & ~st_clr) | st_set;
    next_s.irq    = |(next_s.status & ~next_s.imask);

    rdata = 32'h0000_0000;
    unique case (I_PADDR)
      tec_pkg::TEC_OFS_ENABLE:
      begin
        rdata[tec_pkg::TEC_EN_BIT]   = s.en;
        rdata[tec_pkg::TEC_HALT_BIT] = s.halt;
      end
      tec_pkg::TEC_OFS_RUN:
      begin
        rdata[tec_pkg::TEC_RUN_BIT]  = s.run;
        rdata[tec_pkg::TEC_PRUN_BIT] = s.prun;
      end
      tec_pkg::TEC_OFS_CONTROL:
      begin
        rdata[tec_pkg::TEC_DBUF_BIT]  = s.dbuf;
        rdata[tec_pkg::TEC_TRGF_BIT]  = s.trg_fall;
        rdata[tec_pkg::TEC_START_BIT] = s.start_ext;
      end
      tec_pkg::TEC_OFS_MODE:
      begin
        rdata[tec_pkg::TEC_CLKSEL_LSB +: 2] = s.clk_sel;
        rdata[tec_pkg::TEC_CLREN_BIT]       = s.clr_en;
        rdata[tec_pkg::TEC_CAPM_LSB +: 2]   = s.cap_mode;
        rdata[tec_pkg::TEC_SNAP_BIT]        = 1'h1;
      end
      tec_pkg::TEC_OFS_FFCTRL:
      begin
        rdata[tec_pkg::TEC_FFACT_LSB +: 2] = tec_pkg::TEC_FF_KEEP;
        rdata[tec_pkg::TEC_INV0_BIT]       = s.inv0;
        rdata[tec_pkg::TEC_INV1_BIT]       = s.inv1;
      end
      tec_pkg::TEC_OFS_STATUS:   rdata[tec_pkg::TEC_ST_W-1:0] = s.status;
      tec_pkg::TEC_OFS_MASK:     rdata[tec_pkg::TEC_ST_W-1:0] = s.imask;
      tec_pkg::TEC_OFS_SNAPSHOT: rdata[15:0] = s.snap;
      tec_pkg::TEC_OFS_COMPARE0: rdata[15:0] = s.rg0_buf;
      tec_pkg::TEC_OFS_COMPARE1: rdata[15:0] = s.rg1_buf;
      tec_pkg::TEC_OFS_CAPTURE0: rdata[15:0] = s.cp0;
      tec_pkg::TEC_OFS_CAPTURE1: rdata[15:0] = s.cp1;
      default:                   rdata = 32'h0000_0000;
    endcase
    if (!s.en && !sel_en)
    begin
      rdata = 32'h0000_0000;
    end

    // One wait state, then answer
    next_s.pready  = I_PSEL && I_PENABLE && !s.pready;
    next_s.pslverr = I_PSEL && I_PENABLE && !s.pready && !mapped;
    if (I_PSEL && I_PENABLE && !s.pready)
    begin
      next_s.prdata = (!I_PWRITE && mapped) ? rdata : 32'h0000_0000;
    end
  end

  always_ff @(posedge I_CLK_SYS or posedge I_RST)
  begin
    if (I_RST)
    begin
      s <= TEC_RESET;
    end
    else
    begin
      s <= next_s;
    end
  end

  assign O_PRDATA   = s.prdata;
  assign O_PREADY   = s.pready;
  assign O_PSLVERR  = s.pslverr;
  assign O_IRQ      = s.irq;
  assign O_TIMER_FF = s.tff;

  default clocking tec_cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_RST);

  AST_MATCH0_FLAGS: assert property (match0 |=> s.status[0] && (O_IRQ || s.imask[0]))
    else $error("Compare 0 match did not set its status flag");
  AST_WRAP_RELOAD: assert property (wrap && s.dbuf |=>
    s.cnt == 16'h0000 && s.rg1 == $past(s.rg1_buf))
    else $error("Counter wrap did not clear or reload the compare value");
  AST_CAPTURE_RISE: assert property (ce && rise &&
    s.cap_mode == tec_pkg::TEC_CAP_WIDTH |=> s.cp0 == $past(s.cnt))
    else $error("Rising edge did not capture the counter");
  AST_PERIOD_SHIFT: assert property (ce && rise &&
    s.cap_mode == tec_pkg::TEC_CAP_PERIOD |=> s.cp0 == $past(s.cp1))
    else $error("Period capture did not shift the previous value");
  AST_STOP_CLEARS: assert property (!s.run |=> s.cnt == 16'h0000)
    else $error("Stopped counter was not cleared");
  AST_DECODE_ERR: assert property (I_PSEL && I_PENABLE && !s.pready && !mapped |=>
    O_PREADY && O_PSLVERR)
    else $error("Unmapped address not answered with an error");
  AST_DISABLED_HOLD: assert property (!s.en && !(wr_ok && sel_en) |=>
    $stable(s.cnt) && $stable(s.rg0) && $stable(s.cp1) && $stable(s.imask))
    else $error("Disabled channel changed state");
  AST_DISABLED_READ: assert property (!s.en && !sel_en && I_PSEL && I_PENABLE &&
    !s.pready |=> O_PRDATA == 32'h0000_0000)
    else $error("Disabled channel returned read data");
  AST_HALT_FREEZE: assert property (s.en && s.halt && I_DBG_HALT && s.run |=>
    $stable(s.cnt))
    else $error("Counter moved during debug halt");
  AST_EN_RESERVED: assert property (sel_en && I_PSEL && I_PENABLE && !s.pready |=>
    O_PRDATA[31:8] == 24'h000000 && O_PRDATA[5:0] == 6'h00)
    else $error("Reserved enable bits did not read zero");

  COV_WRAP: cover property (wrap ##1 s.cnt == 16'h0000);
  COV_TRIG_START: cover property (s.start_ext && !s.started ##1 s.started);
  COV_WIDTH: cover property (s.cap_mode == 2'h1 && ce && fall);
  COV_IRQ: cover property (!O_IRQ ##1 O_IRQ);

endmodule // tec_timer_channel

// file: test/tec_timer_channel_test.sv
/*
  Self-checking bench for the timer and event counter channel: APB read and
  write tasks, then register, enable, interrupt, counting, halt, capture and
  flip-flop sequences. Assumes the design answers every APB access with a
  one-cycle O_PREADY and drives no bus error for mapped word addresses.
*/
`timescale 1ns/1ps

module tec_timer_channel_test;

  localparam int unsigned TIMEOUT_CYC = 20000;

  logic        clk;
  logic        rst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic        dbg_halt;
  logic        timer_in;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        timer_ff;
  int          err_count;
  int          n_compared;
  int          cycles;
  logic [31:0] cap0;
  logic [31:0] cap1;

  tec_timer_channel dut_u (
    .I_CLK_SYS  (clk),
    .I_RST      (rst),
    .I_PSEL     (psel),
    .I_PENABLE  (penable),
    .I_PWRITE   (pwrite),
    .I_PADDR    (paddr),
    .I_PWDATA   (pwdata),
    .I_DBG_HALT (dbg_halt),
    .I_TIMER_IN (timer_in),
    .O_PRDATA   (prdata),
    .O_PREADY   (pready),
    .O_PSLVERR  (pslverr),
    .O_IRQ      (irq),
    .O_TIMER_FF (timer_ff)
  );

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    dbg_halt = 1'b0;
    timer_in = 1'b0;
    err_count = 0;
    n_compared = 0;
    cycles = 0;
  end

  always #10 clk = ~clk;

  task automatic complete_run();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles >= TIMEOUT_CYC)
    begin
      err_count = err_count + 1;
      complete_run();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    n_compared = n_compared + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One APB transfer: setup, access held until pready
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50)
      check(32'h0, 32'h1);
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] rd;
    logic        er;
    apb(1'b1, a, d, rd, er);
    check({31'h0, er}, 32'h0);
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] exp, input logic experr);
    logic [31:0] rd;
    logic        er;
    apb(1'b0, a, 32'h0, rd, er);
    check(rd, exp);
    check({31'h0, er}, {31'h0, experr});
  endtask

  task automatic rd_val(input logic [11:0] a, output logic [31:0] d);
    logic er;
    apb(1'b0, a, 32'h0, d, er);
  endtask

  task automatic pulses(input int k);
    repeat (k)
    begin
      @(posedge clk) timer_in <= 1'b1;
      repeat (3) @(posedge clk);
      timer_in <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (6) @(posedge clk);
  endtask

  // Snapshot the counter and compare
  task automatic snap_chk(input logic [7:0] mode, input logic [31:0] exp);
    wr(tec_pkg::TEC_OFS_MODE, {24'h0, mode & 8'hBF});
    rchk(tec_pkg::TEC_OFS_SNAPSHOT, exp, 1'b0);
  endtask

  // Count timer flip-flop changes over a window
  task automatic tog_chk(input int cyc, input int exp);
    int   n;
    logic p;
    n = 0;
    p = timer_ff;
    repeat (cyc)
    begin
      @(posedge clk);
      if (timer_ff !== p)
        n = n + 1;
      p = timer_ff;
    end
    check(n, exp);
  endtask

  logic [1:0] ff_act [4] = '{2'h1, 2'h2, 2'h0, 2'h3};
  logic       ff_exp [4] = '{1'b1, 1'b0, 1'b1, 1'b1};

  initial
  begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rchk(tec_pkg::TEC_OFS_ENABLE, 32'h0, 1'b0);
    wr(tec_pkg::TEC_OFS_COMPARE0, 32'h1234);
    rchk(tec_pkg::TEC_OFS_COMPARE0, 32'h0, 1'b0);
    wr(tec_pkg::TEC_OFS_ENABLE, 32'hFFFF_FFFF);
    rchk(tec_pkg::TEC_OFS_ENABLE, 32'hC0, 1'b0);
    wr(tec_pkg::TEC_OFS_ENABLE, 32'h80);
    rchk(tec_pkg::TEC_OFS_COMPARE0, 32'h0, 1'b0);
    rchk(tec_pkg::TEC_OFS_MODE, 32'h40, 1'b0);
    rchk(tec_pkg::TEC_OFS_FFCTRL, 32'h3, 1'b0);
    rchk(tec_pkg::TEC_OFS_RUN, 32'h0, 1'b0);
    rchk(tec_pkg::TEC_OFS_STATUS, 32'h0, 1'b0);
    rchk(tec_pkg::TEC_OFS_MASK, 32'h0, 1'b0);
    rchk(12'h030, 32'h0, 1'b1);
    rchk(12'h006, 32'h0, 1'b1);
    wr(tec_pkg::TEC_OFS_COMPARE0, 32'h1234);
    rchk(tec_pkg::TEC_OFS_COMPARE0, 32'h1234, 1'b0);
    // Interval timer, clear on compare_1 match
    wr(tec_pkg::TEC_OFS_COMPARE1, 32'h9);
    wr(tec_pkg::TEC_OFS_MODE, 32'h49);
    wr(tec_pkg::TEC_OFS_RUN, 32'h5);
    repeat (60) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    rd_val(tec_pkg::TEC_OFS_STATUS, cap0);
    check(cap0 & 32'h7, 32'h2);
    wr(tec_pkg::TEC_OFS_MASK, 32'h7);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(tec_pkg::TEC_OFS_RUN, 32'h0);
    wr(tec_pkg::TEC_OFS_STATUS, 32'h7);
    rchk(tec_pkg::TEC_OFS_STATUS, 32'h0, 1'b0);
    wr(tec_pkg::TEC_OFS_MASK, 32'h0);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    // Event counting on pin rising edges
    wr(tec_pkg::TEC_OFS_MODE, 32'h40);
    wr(tec_pkg::TEC_OFS_RUN, 32'h1);
    pulses(5);
    snap_chk(8'h40, 32'h5);
    wr(tec_pkg::TEC_OFS_ENABLE, 32'hC0);
    dbg_halt <= 1'b1;
    pulses(3);
    snap_chk(8'h40, 32'h5);
    dbg_halt <= 1'b0;
    pulses(2);
    snap_chk(8'h40, 32'h7);
    wr(tec_pkg::TEC_OFS_ENABLE, 32'h80);
    dbg_halt <= 1'b1;
    pulses(1);
    snap_chk(8'h40, 32'h8);
    dbg_halt <= 1'b0;
    // Pulse width capture at clk/2
    wr(tec_pkg::TEC_OFS_RUN, 32'h0);
    wr(tec_pkg::TEC_OFS_MODE, 32'h51);
    wr(tec_pkg::TEC_OFS_RUN, 32'h5);
    repeat (10) @(posedge clk);
    timer_in <= 1'b1;
    repeat (40) @(posedge clk);
    timer_in <= 1'b0;
    repeat (10) @(posedge clk);
    rd_val(tec_pkg::TEC_OFS_CAPTURE0, cap0);
    rd_val(tec_pkg::TEC_OFS_CAPTURE1, cap1);
    check({31'h0, (cap1 - cap0 >= 32'h13) && (cap1 - cap0 <= 32'h15)}, 32'h1);
    check({31'h0, (cap0 != 32'h0) && (cap1 > cap0)}, 32'h1);
    // Flip-flop write actions
    wr(tec_pkg::TEC_OFS_RUN, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      wr(tec_pkg::TEC_OFS_FFCTRL, {30'h0, ff_act[i]});
      repeat (2) @(posedge clk);
      check({31'h0, timer_ff}, {31'h0, ff_exp[i]});
    end
    // Disable keeps programmed values
    wr(tec_pkg::TEC_OFS_ENABLE, 32'h0);
    rchk(tec_pkg::TEC_OFS_COMPARE1, 32'h0, 1'b0);
    wr(tec_pkg::TEC_OFS_COMPARE1, 32'h55);
    wr(tec_pkg::TEC_OFS_ENABLE, 32'h80);
    rchk(tec_pkg::TEC_OFS_COMPARE1, 32'h9, 1'b0);
    rchk(tec_pkg::TEC_OFS_MODE, 32'h51, 1'b0);
    // Pulse generation on a falling trigger, clk/8, double buffered
    wr(tec_pkg::TEC_OFS_CONTROL, 32'h3);
    wr(tec_pkg::TEC_OFS_COMPARE0, 32'h3);
    wr(tec_pkg::TEC_OFS_COMPARE1, 32'h7);
    wr(tec_pkg::TEC_OFS_CONTROL, 32'h83);
    wr(tec_pkg::TEC_OFS_MODE, 32'h4A);
    wr(tec_pkg::TEC_OFS_FFCTRL, 32'hE);
    wr(tec_pkg::TEC_OFS_STATUS, 32'h7);
    wr(tec_pkg::TEC_OFS_RUN, 32'h5);
    @(posedge clk) timer_in <= 1'b1;
    repeat (40) @(posedge clk);
    snap_chk(8'h4A, 32'h0);
    check({31'h0, timer_ff}, 32'h0);
    timer_in <= 1'b0;
    repeat (8) @(posedge clk);
    tog_chk(128, 4);
    rd_val(tec_pkg::TEC_OFS_STATUS, cap0);
    check(cap0 & 32'h7, 32'h3);
    wr(tec_pkg::TEC_OFS_COMPARE1, 32'hF);
    repeat (70) @(posedge clk);
    tog_chk(256, 4);
    complete_run();
  end

endmodule // tec_timer_channel_test
